// ---- hw/isv_defs.vh ----
// Constants for the interrupt source vectoring block.
// Assumes inclusion by isv_top.v only; holds definitions, no logic.
`ifndef ISV_DEFS_VH
`define ISV_DEFS_VH

// Request numbering
`define ISV_NREQ        24
`define ISV_REQ_W       5
`define ISV_LVL_W       2
`define ISV_LVLREG_W    48
`define ISV_LVL_HALF    24

// Request numbers of the assigned sources
`define ISV_REQ_EXT4    5'd0
`define ISV_REQ_EXT5    5'd1
`define ISV_REQ_EXT26   5'd2
`define ISV_REQ_EXT37   5'd3
`define ISV_REQ_TMR_LO  5'd5
`define ISV_REQ_TMR_HI  5'd6
`define ISV_REQ_SER_RX  5'd7
`define ISV_REQ_SER_TX  5'd8
`define ISV_REQ_ADC     5'd18
`define ISV_REQ_TBT     5'd19
`define ISV_REQ_WPS     5'd20
`define ISV_REQ_FLASH   5'd23

// Requests that have a source; 4, 9..17, 21, 22 stay zero
`define ISV_REQ_USED    24'h9c01ef

// Vector table: request 0 upper byte at the top, two bytes per request
`define ISV_VEC_TOP     16'hfffa
`define ISV_VEC_LO_OFS  16'h0001

// APB register byte offsets
`define ISV_OFS_PEND    12'h000
`define ISV_OFS_MASK    12'h004
`define ISV_OFS_LVL_LO  12'h008
`define ISV_OFS_LVL_HI  12'h00c
`define ISV_OFS_WIN     12'h010
`define ISV_OFS_CLR     12'h014

// Reset values
`define ISV_MASK_RST    24'h000000
`define ISV_LVL_RST     48'hffffffffffff
`define ISV_PEND_RST    1'b0
`define ISV_NUM_NONE    5'd0
`define ISV_LVL_NONE    2'd3
`define ISV_LVL_OUT_RST 2'd0
`define ISV_RDATA_RST   32'h00000000

`endif

// ---- hw/isv_top.v ----
// Interrupt source vectoring: latches peripheral events into 24 numbered requests,
// applies per-request two-bit levels and picks the winning request and its vector.
// Assumes one clock, APB register access and one-cycle event pulses from peripherals.
// Peripheral inputs may also be held high; a held level keeps re-setting its request.
// Register map (byte offsets, data in bits 23:0, upper bits read as zero)
//   00h  pending   read only; a read returns and clears every latched request
//   04h  mask      read/write; 1 lets a pending request reach the core, reset 0
//   08h  level lo  read/write; requests 0 to 11, reset all ones
//   0ch  level hi  read/write; requests 12 to 23, reset all ones
//   10h  winner    read only; bit 8 found, bits 7:6 level, bits 5:1 request number
//   14h  clear     write only; each 1 drops that pending request
//   Request k of a level half sits at bits 2k+1:2k counted from that half's first request.
//   Any other offset answers with pslverr, ignores writes and reads as zero.
//
// Level value 0 is the most urgent. A request that arrives in the cycle that clears
// it stays pending, so a late event is never lost to a read or a clear.
//
// The core sees the winner two clocks after the event: one to latch, one to register.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "isv_defs.vh"

module isv_top (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rst,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [11:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    // Peripheral event pulses
    input  wire        i_ext_irq2,
    input  wire        i_ext_irq3,
    input  wire        i_ext_irq4,
    input  wire        i_ext_irq5,
    input  wire        i_ext_irq6,
    input  wire        i_ext_irq7,
    input  wire        i_tmr_lo,
    input  wire        i_tmr_hi,
    input  wire        i_ser_rx,
    input  wire        i_ser_tx,
    input  wire        i_adc,
    input  wire        i_tbt,
    input  wire        i_wps,
    input  wire        i_flash,
    // Core side
    output reg         o_irq,
    output reg  [4:0]  o_req_num,
    output reg  [1:0]  o_req_level,
    output reg  [15:0] o_vec_upper_addr,
    output reg  [15:0] o_vec_lower_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // Source to request mapping
    // Shared requests OR their channels; the peripheral tells them apart.

    reg [23:0] src_vec;

    always @* begin
        src_vec = 24'h000000;
        src_vec[`ISV_REQ_EXT4]   = i_ext_irq4;
        src_vec[`ISV_REQ_EXT5]   = i_ext_irq5;
        src_vec[`ISV_REQ_EXT26]  = i_ext_irq2 | i_ext_irq6;
        src_vec[`ISV_REQ_EXT37]  = i_ext_irq3 | i_ext_irq7;
        src_vec[`ISV_REQ_TMR_LO] = i_tmr_lo;
        src_vec[`ISV_REQ_TMR_HI] = i_tmr_hi;
        src_vec[`ISV_REQ_SER_RX] = i_ser_rx;
        src_vec[`ISV_REQ_SER_TX] = i_ser_tx;
        src_vec[`ISV_REQ_ADC]    = i_adc;
        src_vec[`ISV_REQ_TBT]    = i_tbt;
        src_vec[`ISV_REQ_WPS]    = i_wps;
        src_vec[`ISV_REQ_FLASH]  = i_flash;
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    // Only exact word offsets decode; there are no byte lanes.

    wire        acc    = i_psel & i_penable;
    wire        wr_acc = acc & i_pwrite;
    wire        rd_acc = acc & ~i_pwrite;
    wire        hit_pend = (i_paddr == `ISV_OFS_PEND);
    wire        hit_mask = (i_paddr == `ISV_OFS_MASK);
    wire        hit_lvlo = (i_paddr == `ISV_OFS_LVL_LO);
    wire        hit_lvhi = (i_paddr == `ISV_OFS_LVL_HI);
    wire        hit_win  = (i_paddr == `ISV_OFS_WIN);
    wire        hit_clr  = (i_paddr == `ISV_OFS_CLR);
    wire        hit_any  = hit_pend | hit_mask | hit_lvlo | hit_lvhi | hit_win | hit_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Pending, mask and level registers

    reg  [23:0] mask_q;
    reg  [47:0] lvl_q;
    wire [23:0] pend_q;
    wire [23:0] pend_clr;
    wire        rd_clear = rd_acc & hit_pend & ~o_pready;
    wire        wr_clear = wr_acc & hit_clr & ~o_pready;

    // Read-to-clear and the clear register both act at the accepting edge only
    assign pend_clr = {`ISV_NREQ{rd_clear}} | ({`ISV_NREQ{wr_clear}} & i_pwdata[`ISV_NREQ-1:0]);

    // One sticky cell per request; requests without a source are built tied off
    genvar g;
    generate
        for (g = 0; g < `ISV_NREQ; g = g + 1) begin : g_pend
            isv_pend_cell #(
                .USED   ((`ISV_REQ_USED >> g) & 1'b1)
            ) u_pend (
                .i_clk  (i_clk),
                .i_rst  (i_rst),
                .i_set  (src_vec[g]),
                .i_clr  (pend_clr[g]),
                .o_pend (pend_q[g])
            );
        end
    endgenerate

    // Mask and level writes land on the accepting edge, as the clears above do
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mask_q <= `ISV_MASK_RST;
            lvl_q  <= `ISV_LVL_RST;
        end else if (wr_acc && !o_pready) begin
            if (hit_mask)
                mask_q <= i_pwdata[`ISV_NREQ-1:0];
            if (hit_lvlo)
                lvl_q[`ISV_LVL_HALF-1:0] <= i_pwdata[`ISV_LVL_HALF-1:0];
            if (hit_lvhi)
                lvl_q[`ISV_LVLREG_W-1:`ISV_LVL_HALF] <= i_pwdata[`ISV_LVL_HALF-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration: lowest level value wins, then lowest request number

    wire [23:0]  act = pend_q & mask_q;
    wire [24:0]  ch_found;
    wire [124:0] ch_num;
    wire [49:0]  ch_lvl;
    wire         found;
    wire [4:0]   best_num;
    wire [1:0]   best_lvl;

    // The chain starts empty above request 23
    assign ch_found[`ISV_NREQ]                        = 1'b0;
    assign ch_num[`ISV_NREQ*`ISV_REQ_W +: `ISV_REQ_W] = `ISV_NUM_NONE;
    assign ch_lvl[`ISV_NREQ*`ISV_LVL_W +: `ISV_LVL_W] = `ISV_LVL_NONE;

    // Walking down from request 23, a tie hands the slot to the lower number.
    // The chain of 24 cells is the longest path in the block; split it into two
    // registered halves first if timing ever gets tight.
    generate
        for (g = 0; g < `ISV_NREQ; g = g + 1) begin : g_arb
            isv_arb_cell #(
                .IDX     (g)
            ) u_arb (
                .i_act   (act[g]),
                .i_lvl   (lvl_q[`ISV_LVL_W*g +: `ISV_LVL_W]),
                .i_found (ch_found[g+1]),
                .i_num   (ch_num[`ISV_REQ_W*(g+1) +: `ISV_REQ_W]),
                .i_best  (ch_lvl[`ISV_LVL_W*(g+1) +: `ISV_LVL_W]),
                .o_found (ch_found[g]),
                .o_num   (ch_num[`ISV_REQ_W*g +: `ISV_REQ_W]),
                .o_best  (ch_lvl[`ISV_LVL_W*g +: `ISV_LVL_W])
            );
        end
    endgenerate

    assign found    = ch_found[0];
    assign best_num = ch_num[`ISV_REQ_W-1:0];
    assign best_lvl = ch_lvl[`ISV_LVL_W-1:0];

    wire [15:0] vec_up = `ISV_VEC_TOP - {10'h000, best_num, 1'b0};
    wire [15:0] vec_lo = vec_up + `ISV_VEC_LO_OFS;

    // Core-side outputs are registered so the core samples a settled winner
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq            <= 1'b0;
            o_req_num        <= `ISV_NUM_NONE;
            o_req_level      <= `ISV_LVL_OUT_RST;
            o_vec_upper_addr <= `ISV_VEC_TOP;
            o_vec_lower_addr <= `ISV_VEC_TOP + `ISV_VEC_LO_OFS;
        end else begin
            o_irq            <= found;
            o_req_num        <= best_num;
            o_req_level      <= best_lvl;
            o_vec_upper_addr <= vec_up;
            o_vec_lower_addr <= vec_lo;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB answer: one wait state, ready pulses in the second access cycle
    // The access phase is accepted on its first cycle, so registers change there
    // and ready follows one clock later; the master keeps the request up meanwhile.
    // Read data and slave error stand for that one ready cycle only, zero otherwise.

    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h00000000;
        case (1'b1)
            hit_pend: rd_mux = {8'h00, pend_q};
            hit_mask: rd_mux = {8'h00, mask_q};
            hit_lvlo: rd_mux = {8'h00, lvl_q[23:0]};
            hit_lvhi: rd_mux = {8'h00, lvl_q[47:24]};
            hit_win:  rd_mux = {23'h000000, found, best_lvl, best_num, 1'b0};
            default:  rd_mux = 32'h00000000;
        endcase
    end

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= `ISV_RDATA_RST;
        end else begin
            o_pready  <= acc & ~o_pready;
            o_pslverr <= acc & ~o_pready & ~hit_any;
            o_prdata  <= (rd_acc && !o_pready) ? rd_mux : 32'h00000000;
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Pending cell: sticky request bit; a set in the clearing cycle wins
// Requests without a source are built with USED at zero and read as zero,
// so software never sees a request that no peripheral can raise.

module isv_pend_cell #(
    parameter USED = 1
) (
    // Clock and reset
    input  wire i_clk,
    input  wire i_rst,
    // Event and acknowledge
    input  wire i_set,
    input  wire i_clr,
    // Latched request
    output reg  o_pend
);

    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst)
            o_pend <= `ISV_PEND_RST;
        else
            o_pend <= (USED != 0) & (i_set | (o_pend & ~i_clr));
    end

endmodule

////////////////////////////////////////////////////////////////////////////////
// Arbitration cell: keeps the incoming candidate or takes this request
// Each cell is a two-bit compare and a mux, so the chain stays small in area
// at the cost of one long combinational path.

module isv_arb_cell #(
    parameter IDX = 0
) (
    // This request
    input  wire       i_act,
    input  wire [1:0] i_lvl,
    // Candidate from the higher numbers
    input  wire       i_found,
    input  wire [4:0] i_num,
    input  wire [1:0] i_best,
    // Candidate passed on
    output wire       o_found,
    output wire [4:0] o_num,
    output wire [1:0] o_best
);

    // Equal levels take this request, which is the lower number of the two
    wire take = i_act & (~i_found | (i_lvl <= i_best));

    assign o_found = i_found | i_act;
    assign o_num   = take ? IDX[4:0] : i_num;
    assign o_best  = take ? i_lvl : i_best;

endmodule

`default_nettype wire

// ---- sim/isv_core_model.sv ----
// Core model: latches the vector pair it would fetch on a rising request.
// Assumes the core-side outputs of isv_top.
`timescale 1ns/1ps
`default_nettype none
module isv_core_model (
    input  wire logic        i_clk,
    input  wire logic        i_irq,
    input  wire logic [15:0] i_up,
    input  wire logic [15:0] i_lo,
    output var  logic [15:0] o_fetch_up = 16'h0000,
    output var  logic [15:0] o_fetch_lo = 16'h0000
);
    logic irq_q = 1'b0;
    // Only a fresh request starts a fetch, as a real core would
    always @(posedge i_clk) begin
        irq_q <= i_irq;
        if (i_irq && !irq_q) begin
            o_fetch_up <= i_up;
            o_fetch_lo <= i_lo;
        end
    end
endmodule
`default_nettype wire

// ---- sim/isv_top_assertions.sv ----
// Checker for isv_top: winner number against its vector pair.
// Assumes binding onto isv_top with one clock and active-high reset.
`timescale 1ns/1ps
`default_nettype none
module isv_chk (
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic        o_irq,
    input wire logic [4:0]  o_req_num,
    input wire logic [15:0] o_vec_upper_addr,
    input wire logic [15:0] o_vec_lower_addr
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    ////////////////////////////////////////////////////////////////
    property p_vec_lo; o_vec_lower_addr == o_vec_upper_addr + 16'h0001; endproperty
    a_vec_lo: assert property (p_vec_lo) else $error("lower vector not upper plus one");
    property p_vec_up; o_vec_upper_addr == 16'hfffa - {10'h000, o_req_num, 1'b0}; endproperty
    a_vec_up: assert property (p_vec_up) else $error("upper vector off its slot");
    property p_vec_track; $stable(o_req_num) |-> $stable(o_vec_upper_addr); endproperty
    a_vec_track: assert property (p_vec_track) else $error("vector moved alone");
    property p_unused; o_irq |-> !(o_req_num inside {5'd4, [5'd9:5'd17], 5'd21, 5'd22}); endproperty
    a_unused: assert property (p_unused) else $error("unassigned request won");
    property p_req0; o_req_num == 5'd0 |-> o_vec_upper_addr == 16'hfffa; endproperty
    a_req0: assert property (p_req0) else $error("request 0 vector wrong");
    property p_req1; o_req_num == 5'd1 |-> o_vec_lower_addr == 16'hfff9; endproperty
    a_req1: assert property (p_req1) else $error("request 1 vector wrong");
    property p_req18; o_req_num == 5'd18 |-> o_vec_upper_addr == 16'hffd6; endproperty
    a_req18: assert property (p_req18) else $error("request 18 vector wrong");
    property p_req23; o_req_num == 5'd23 |-> o_vec_lower_addr == 16'hffcd; endproperty
    a_req23: assert property (p_req23) else $error("request 23 vector wrong");
    cover property (o_irq && o_req_num == 5'd2);
    cover property (o_irq && o_req_num == 5'd18);
    cover property (o_irq && o_req_num == 5'd23);
endmodule
bind isv_top isv_chk u_chk (
    .i_clk, .i_rst, .o_irq, .o_req_num, .o_vec_upper_addr, .o_vec_lower_addr
);
`default_nettype wire

// ---- sim/test_interrupt_source_vectoring.sv ----
// Testbench for isv_top: APB register traffic and event-to-vector checks.
// Assumes isv_top, its bound checker and the core model.
`timescale 1ns/1ps
`default_nettype none
module test_interrupt_source_vectoring;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, err;
    logic [11:0] padr = 12'h000;
    logic [31:0] pwd = 32'h0, rd;
    logic [13:0] src = 14'h0000;
    wire  [31:0] prdata;
    wire         pready, pslverr, irq;
    wire  [4:0]  num;
    wire  [1:0]  lvl;
    wire  [15:0] up, lo, fup, flo;
    int          fails = 0, checks_done = 0;
    logic [4:0]  rq [14] = '{2, 3, 0, 1, 2, 3, 5, 6, 7, 8, 18, 19, 20, 23};
    always #2 i_clk = ~i_clk;
    ////////////////////////////////////////////////////////////////
    isv_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_ext_irq2(src[0]), .i_ext_irq3(src[1]), .i_ext_irq4(src[2]), .i_ext_irq5(src[3]),
        .i_ext_irq6(src[4]), .i_ext_irq7(src[5]), .i_tmr_lo(src[6]), .i_tmr_hi(src[7]),
        .i_ser_rx(src[8]), .i_ser_tx(src[9]), .i_adc(src[10]), .i_tbt(src[11]), .i_wps(src[12]),
        .i_flash(src[13]), .o_irq(irq), .o_req_num(num), .o_req_level(lvl),
        .o_vec_upper_addr(up), .o_vec_lower_addr(lo));
    isv_core_model u_core (.i_clk(i_clk), .i_irq(irq), .i_up(up), .i_lo(lo),
        .o_fetch_up(fup), .o_fetch_lo(flo));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // Entered just after an edge; ends one idle edge later so psel is set once per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        padr <= a;
        pwd <= d;
        @(posedge i_clk) pen <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (n >= 50) fails++;
        @(posedge i_clk);
    endtask
    task automatic pulse(input logic [13:0] s);
        src <= s;
        @(posedge i_clk) src <= 14'h0000;
        repeat (2) @(posedge i_clk);
    endtask
    task automatic give_verdict;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        apb(1'b0, 12'h008, 32'h0);
        chk("level reset", rd, 32'h00ffffff);
        apb(1'b1, 12'h004, 32'h00ffffff);
        for (int i = 0; i < 14; i++) begin
            pulse(14'h0001 << i);
            chk("irq", 32'(irq), 32'h1);
            chk("req", 32'(num), 32'(rq[i]));
            chk("upper", 32'(up), 32'hfffa - 32'(rq[i]) * 2);
            apb(1'b0, 12'h000, 32'h0);
            chk("pending", rd, 32'h1 << rq[i]);
            chk("fetch", 32'(flo), 32'hfffb - 32'(rq[i]) * 2);
        end
        pulse(14'h2400);
        chk("same level", 32'(num), 32'd18);
        apb(1'b0, 12'h000, 32'h0);
        chk("both pending", rd, 32'h00840000);
        apb(1'b1, 12'h00c, 32'h003fffff);
        pulse(14'h2400);
        chk("lower level", 32'(num), 32'd23);
        chk("level", 32'(lvl), 32'd0);
        apb(1'b0, 12'h010, 32'h0);
        chk("winner", rd, 32'h0000012e);
        apb(1'b1, 12'h014, 32'h00ffffff);
        repeat (2) @(posedge i_clk);
        chk("cleared", 32'(irq), 32'h0);
        apb(1'b1, 12'h004, 32'h0);
        pulse(14'h0400);
        chk("masked", 32'(irq), 32'h0);
        apb(1'b0, 12'h000, 32'h0);
        chk("masked pending", rd, 32'h00040000);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped", 32'(err), 32'h1);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        apb(1'b0, 12'h00c, 32'h0);
        chk("level after reset", rd, 32'h00ffffff);
        give_verdict();
    end
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
